// file: hw/alu_status_pkg.sv
// Shared constants and types for the ALU with status flags and product registers.
package alu_status_pkg;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  // ==========================================================================
  localparam logic [7:0] IDX_COMMAND = 8'h00;
  localparam logic [7:0] IDX_ARITH_STATUS = 8'h04;
  localparam logic [7:0] IDX_MULT_LOW = 8'h18;
  localparam logic [7:0] IDX_MULT_HIGH = 8'h19;
  localparam logic [7:0] IDX_SCRATCH = 8'h1a;
  localparam logic [7:0] IDX_WORKING = 8'h1b;

  // ==========================================================================
  // Status register fields
  // ==========================================================================
  localparam int BIT_CARRY = 0;
  localparam int BIT_HALF_BORROW = 1;
  localparam int BIT_ZERO = 2;
  localparam int BIT_SIGN_ERROR = 3;
  localparam int INDIRECT_LSB = 4;
  localparam logic [7:0] STATUS_POR_VALUE = 8'hf0;
  localparam logic [3:0] INDIRECT_SOFT_VALUE = 4'hf;
  localparam logic [7:0] WORKING_RESET_VALUE = 8'h00;
  localparam logic [7:0] SCRATCH_RESET_VALUE = 8'h00;
  localparam logic [23:0] COMMAND_RESET_VALUE = 24'h000000;

  // ==========================================================================
  // Command word fields
  // ==========================================================================
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_OP_W = 5;
  localparam int CMD_SRC_BIT = 5;
  localparam int CMD_DEST_BIT = 6;
  localparam int CMD_FILE_LSB = 8;
  localparam int CMD_IMM_LSB = 16;

  typedef enum logic [4:0] {
    OP_ADD, OP_ADDC, OP_SUB, OP_SUBB, OP_AND, OP_IOR, OP_XOR, OP_MUL,
    OP_MOVF, OP_CLR, OP_SET, OP_INC, OP_DEC, OP_COMP, OP_NEG, OP_RLC,
    OP_RRC, OP_SWAP, OP_BCLR, OP_BSET, OP_MOVE_W_TO_FILE_OP, OP_NONE
  } aluOp_e;

endpackage

// file: hw/alu_if.sv
// Operand, result and flag bundle between the register block and the ALU core.
interface alu_if;
  import alu_status_pkg::*;
  aluOp_e op;
  logic [7:0] wVal;
  logic [7:0] opVal;
  logic carryIn;
  logic [7:0] result;
  logic [3:0] flags;
  logic [3:0] updMask;
  logic writesDest;
  logic [15:0] product;
  modport core (input op, wVal, opVal, carryIn,
    output result, flags, updMask, writesDest, product);
  modport user (output op, wVal, opVal, carryIn,
    input result, flags, updMask, writesDest, product);
endinterface

// file: hw/alu_core.sv
// Combinational arithmetic and logic core with flag generation and 8x8 multiply.
module alu_core
  import alu_status_pkg::*;
(
  alu_if.core alu
);

  logic [7:0] addA;
  logic [7:0] addB;
  logic addCin;
  logic [8:0] fullSum;
  logic [4:0] lowSum;
  logic signErr;

  // ==========================================================================
  // Adder operand steering
  // ==========================================================================
  always_comb
  begin
    addA = alu.wVal;
    addB = alu.opVal;
    addCin = 1'b0;
    case (alu.op)
      OP_ADDC: addCin = alu.carryIn;
      // Subtraction adds the inverted subtrahend, so carry out low means a borrow.
      OP_SUB:
      begin
        addA = alu.opVal; // RL4
        addB = ~alu.wVal;
        addCin = 1'b1;
      end
      OP_SUBB:
      begin
        addA = alu.opVal; // RL4
        addB = ~alu.wVal;
        addCin = alu.carryIn;
      end
      OP_INC:
      begin
        addA = alu.opVal;
        addB = 8'h00;
        addCin = 1'b1;
      end
      OP_DEC:
      begin
        addA = alu.opVal;
        addB = 8'hff;
      end
      OP_NEG:
      begin
        addA = 8'h00;
        addB = ~alu.opVal;
        addCin = 1'b1;
      end
      default: ;
    endcase
  end

  assign fullSum = {1'b0, addA} + {1'b0, addB} + {8'h00, addCin};
  assign lowSum = {1'b0, addA[3:0]} + {1'b0, addB[3:0]} + {4'h0, addCin};
  assign signErr = (addA[7] == addB[7]) && (fullSum[7] != addA[7]); // RL5
  assign alu.product = {8'h00, alu.wVal} * {8'h00, alu.opVal};

  // ==========================================================================
  // Result and flags
  // ==========================================================================
  always_comb
  begin
    alu.result = fullSum[7:0];
    alu.flags = 4'h0;
    alu.updMask = 4'h0;
    alu.writesDest = 1'b1;
    case (alu.op)
      OP_ADD, OP_ADDC, OP_SUB, OP_SUBB, OP_INC, OP_DEC, OP_NEG:
        alu.updMask = 4'hf;
      OP_AND:
      begin
        alu.result = alu.wVal & alu.opVal;
        alu.updMask[BIT_ZERO] = 1'b1;
      end
      OP_IOR:
      begin
        alu.result = alu.wVal | alu.opVal;
        alu.updMask[BIT_ZERO] = 1'b1;
      end
      OP_XOR:
      begin
        alu.result = alu.wVal ^ alu.opVal;
        alu.updMask[BIT_ZERO] = 1'b1;
      end
      OP_MOVF:
      begin
        alu.result = alu.opVal;
        alu.updMask[BIT_ZERO] = 1'b1;
      end
      OP_CLR:
      begin
        alu.result = 8'h00;
        alu.updMask[BIT_ZERO] = 1'b1; // RL2
      end
      OP_COMP:
      begin
        alu.result = ~alu.opVal;
        alu.updMask[BIT_ZERO] = 1'b1;
      end
      OP_RLC:
      begin
        alu.result = {alu.opVal[6:0], alu.carryIn};
        alu.updMask[BIT_CARRY] = 1'b1;
      end
      OP_RRC:
      begin
        alu.result = {alu.carryIn, alu.opVal[7:1]};
        alu.updMask[BIT_CARRY] = 1'b1;
      end
      OP_SET: alu.result = 8'hff;
      OP_SWAP: alu.result = {alu.opVal[3:0], alu.opVal[7:4]}; // RL3
      OP_BCLR, OP_BSET: alu.result = alu.opVal;
      OP_MOVE_W_TO_FILE_OP: alu.result = alu.wVal; // RL3
      default: alu.writesDest = 1'b0;
    endcase
    alu.flags[BIT_CARRY] = fullSum[8];
    if (alu.op == OP_RLC)
      alu.flags[BIT_CARRY] = alu.opVal[7];
    if (alu.op == OP_RRC)
      alu.flags[BIT_CARRY] = alu.opVal[0];
    alu.flags[BIT_HALF_BORROW] = lowSum[4]; // RL4
    alu.flags[BIT_ZERO] = (alu.result == 8'h00); // RL12
    alu.flags[BIT_SIGN_ERROR] = signErr; // RL5
  end

endmodule

// file: hw/alu_status_flags.sv
// Register block of the ALU: status flags, working register, product bytes, bus slave.
//
// Design decision made here: the Wishbone interface to the registers.

// How it works
// RL1: Flag-updating ops writing the status register keep flag bits from the flag logic.
// RL2: Clearing the status register gives 0000u1uu: upper zero, zero flag set.
// RL3: Bit clear, bit set, swap and move-W-to-file leave all flags untouched.
// RL4: Subtraction uses carry and half-borrow flags as inverted borrow outputs.
// RL5: Signed overflow beyond +127 or below -128 sets the sign error flag.
// RL6: Single-operand ops read either the working register or a file register.
// RL7: Two-operand ops use the working register plus a file or 8-bit immediate.
// RL8: The status register is a valid destination like any other file register.
// RL9: Product readable as unbanked bytes: low at 18h, high at 19h.
// RL10: Product bytes are unreset: undefined at power-on, kept on other resets.
// RL11: Status at 04h; bits 7:4 indirect mode, power-on ones; 3:0 flags.
// RL12: Zero flag set when the 8-bit result is zero, cleared otherwise.
module alu_status_flags
  import alu_status_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic extResetPin,
  input wire logic watchdogReset,
  output logic [3:0] indirectModeBits,
  output logic [3:0] arithFlags
);

  logic [1:0] extPinSync;
  logic [1:0] wdogSync;
  logic softReset;
  logic [7:0] arithStatusReg;
  logic [7:0] workingRegister;
  logic [7:0] multResultLow;
  logic [7:0] multResultHigh;
  logic [7:0] scratchFile;
  logic [23:0] lastCommand;
  logic [7:0] busIndex;
  logic busTake;
  logic busWrite;
  logic cmdExec;
  aluOp_e cmdOp;
  logic cmdSrcSel;
  logic cmdDestFile;
  logic [7:0] cmdFile;
  logic [7:0] cmdImm;
  logic [7:0] fileValue;
  logic [7:0] bitMask;
  logic [7:0] next_result;
  logic destIsFile;
  logic [7:0] destAddr;
  logic writeFile;
  logic writeWorking;
  logic [7:0] statusMerge;

  alu_if alu ();

  alu_core u_core (
    .alu(alu.core)
  );

  // ==========================================================================
  // File space decode
  // ==========================================================================
  function automatic logic [7:0] readFile(
    input logic [7:0] addr,
    input logic [7:0] status,
    input logic [7:0] lowByte,
    input logic [7:0] highByte,
    input logic [7:0] scratch,
    input logic [7:0] working
  );
    logic [7:0] value;
    value = 8'h00;
    case (addr)
      IDX_ARITH_STATUS: value = status; // RL11
      IDX_MULT_LOW: value = lowByte; // RL9
      IDX_MULT_HIGH: value = highByte; // RL9
      IDX_SCRATCH: value = scratch;
      IDX_WORKING: value = working;
      default: value = 8'h00;
    endcase
    return value;
  endfunction

  // ==========================================================================
  // Reset pin synchronisers
  // ==========================================================================
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      extPinSync <= 2'b00;
      wdogSync <= 2'b00;
    end
    else
    begin
      extPinSync <= {extPinSync[0], extResetPin};
      wdogSync <= {wdogSync[0], watchdogReset};
    end
  end

  // Either non-power-up reset holds the block in its soft reset state.
  assign softReset = extPinSync[1] | wdogSync[1];

  // ==========================================================================
  // Wishbone slave
  // ==========================================================================
  assign busIndex = {2'b00, adr_i[7:2]};
  assign busTake = cyc_i & stb_i & ~ack_o;
  // Writes land on the edge where the master sees ack, as classic cycles demand.
  assign busWrite = cyc_i & stb_i & we_i & ack_o;

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      ack_o <= 1'b0;
    else
      ack_o <= busTake;
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      dat_o <= 32'h00000000;
    else if (busTake)
    begin
      if (busIndex == IDX_COMMAND)
        dat_o <= {8'h00, lastCommand};
      else
        dat_o <= {24'h000000, readFile(busIndex, arithStatusReg, multResultLow,
          multResultHigh, scratchFile, workingRegister)};
    end
  end

  // ==========================================================================
  // Command decode and operand selection
  // ==========================================================================
  assign cmdOp = aluOp_e'(dat_i[CMD_OP_LSB +: CMD_OP_W]);
  assign cmdSrcSel = dat_i[CMD_SRC_BIT];
  assign cmdDestFile = dat_i[CMD_DEST_BIT];
  assign cmdFile = dat_i[CMD_FILE_LSB +: 8];
  assign cmdImm = dat_i[CMD_IMM_LSB +: 8];
  // A command needs its three low lanes; a partial write is dropped as a whole.
  assign cmdExec = busWrite & (busIndex == IDX_COMMAND) & (sel_i[2:0] == 3'b111)
    & ~softReset;

  assign fileValue = readFile(cmdFile, arithStatusReg, multResultLow,
    multResultHigh, scratchFile, workingRegister);
  assign bitMask = 8'h01 << cmdImm[2:0];

  always_comb
  begin
    alu.op = cmdExec ? cmdOp : OP_NONE;
    alu.wVal = workingRegister;
    alu.carryIn = arithStatusReg[BIT_CARRY];
    alu.opVal = fileValue;
    case (cmdOp)
      OP_ADD, OP_ADDC, OP_SUB, OP_SUBB, OP_AND, OP_IOR, OP_XOR, OP_MUL:
        alu.opVal = cmdSrcSel ? cmdImm : fileValue; // RL7
      OP_MOVF, OP_CLR, OP_SET, OP_INC, OP_DEC, OP_COMP, OP_NEG, OP_RLC,
      OP_RRC, OP_SWAP:
        alu.opVal = cmdSrcSel ? workingRegister : fileValue; // RL6
      default: alu.opVal = fileValue;
    endcase
  end

  always_comb
  begin
    next_result = alu.result;
    destIsFile = cmdDestFile;
    case (cmdOp)
      OP_BCLR:
      begin
        next_result = fileValue & ~bitMask; // RL3
        destIsFile = 1'b1;
      end
      OP_BSET:
      begin
        next_result = fileValue | bitMask; // RL3
        destIsFile = 1'b1;
      end
      OP_MOVE_W_TO_FILE_OP: destIsFile = 1'b1;
      default: ;
    endcase
  end

  assign destAddr = cmdFile;
  assign writeFile = cmdExec & alu.writesDest & destIsFile;
  assign writeWorking = cmdExec & alu.writesDest & ~destIsFile;

  // ==========================================================================
  // Status register update
  // ==========================================================================
  // Any flag-updating op that targets the status register loses its write to
  // the flag nibble: updated bits come from the flags, the rest stay put.
  always_comb
  begin
    statusMerge[7:4] = next_result[7:4];
    if (alu.updMask != 4'h0)
      statusMerge[3:0] = (arithStatusReg[3:0] & ~alu.updMask)
        | (alu.flags & alu.updMask); // RL1 RL2
    else
      statusMerge[3:0] = next_result[3:0]; // RL8
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      arithStatusReg <= STATUS_POR_VALUE; // RL11
    else if (softReset)
      arithStatusReg[7:4] <= INDIRECT_SOFT_VALUE;
    else if (busWrite && busIndex == IDX_ARITH_STATUS && sel_i[0])
      arithStatusReg <= dat_i[7:0];
    else if (writeFile && destAddr == IDX_ARITH_STATUS)
      arithStatusReg <= statusMerge; // RL1 RL8
    else if (cmdExec)
      arithStatusReg[3:0] <= (arithStatusReg[3:0] & ~alu.updMask)
        | (alu.flags & alu.updMask); // RL3 RL12
  end

  // ==========================================================================
  // Working register and scratch file
  // ==========================================================================
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      workingRegister <= WORKING_RESET_VALUE;
    else if (busWrite && busIndex == IDX_WORKING && sel_i[0])
      workingRegister <= dat_i[7:0];
    else if (writeWorking || (writeFile && destAddr == IDX_WORKING))
      workingRegister <= next_result;
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      scratchFile <= SCRATCH_RESET_VALUE;
    else if (busWrite && busIndex == IDX_SCRATCH && sel_i[0])
      scratchFile <= dat_i[7:0];
    else if (writeFile && destAddr == IDX_SCRATCH)
      scratchFile <= next_result;
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      lastCommand <= COMMAND_RESET_VALUE;
    else if (cmdExec)
      lastCommand <= dat_i[23:0];
  end

  // ==========================================================================
  // Product registers
  // ==========================================================================
  // No reset on purpose: power-on leaves them unknown and the soft resets
  // must not disturb a product that software may still want to read.
  always_ff @(posedge clk_sys)
  begin
    if (busWrite && busIndex == IDX_MULT_LOW && sel_i[0])
      multResultLow <= dat_i[7:0]; // RL10
    else if (cmdExec && cmdOp == OP_MUL)
      multResultLow <= alu.product[7:0]; // RL9
    else if (writeFile && destAddr == IDX_MULT_LOW)
      multResultLow <= next_result;
  end

  always_ff @(posedge clk_sys)
  begin
    if (busWrite && busIndex == IDX_MULT_HIGH && sel_i[0])
      multResultHigh <= dat_i[7:0]; // RL10
    else if (cmdExec && cmdOp == OP_MUL)
      multResultHigh <= alu.product[15:8]; // RL9
    else if (writeFile && destAddr == IDX_MULT_HIGH)
      multResultHigh <= next_result;
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign indirectModeBits = arithStatusReg[7:4];
  assign arithFlags = arithStatusReg[3:0];

endmodule

// file: tb/alu_status_flags_assertions.sv
// Concurrent checks on the bus and status ports of the ALU register block.
module alu_status_flags_assertions
  import alu_status_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic extResetPin,
  input wire logic watchdogReset,
  input wire logic [3:0] indirectModeBits,
  input wire logic [3:0] arithFlags
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  // ==========================================================================
  // Request sequences
  // ==========================================================================
  sequence reqTaken;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence statusRead;
    reqTaken ##0 !we_i && adr_i == 8'h10;
  endsequence
  sequence statusWrite;
    reqTaken ##0 we_i && sel_i[0] && adr_i == 8'h10 && !extResetPin && !watchdogReset;
  endsequence

  // ==========================================================================
  // Assertions
  // ==========================================================================
  a_ack_latency: assert property (reqTaken |=> ack_o)
    else $error("ack did not follow a request by one cycle");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack stayed high longer than one cycle");
  a_ack_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
    else $error("ack rose without a request");
  a_flags_quiet: assert property (!ack_o |=> $stable(arithFlags))
    else $error("flags changed without a bus transfer");
  a_status_read: assert property (statusRead |=>
    dat_o == {24'h0, $past(indirectModeBits), $past(arithFlags)})
    else $error("status read data differs from status ports");
  a_status_write: assert property (statusWrite |=> ##1
    {indirectModeBits, arithFlags} == $past(dat_i[7:0], 2))
    else $error("status write not applied");
  a_unmapped_read: assert property (reqTaken ##0 !we_i && adr_i == 8'h20 |=> dat_o == 32'h0)
    else $error("unmapped read returned nonzero data");
  a_por_indirect: assert property ($fell(sys_rst) |-> indirectModeBits == 4'hf)
    else $error("indirect bits not ones after power-on reset");
  a_soft_indirect: assert property ((extResetPin || watchdogReset) [*5] |->
    indirectModeBits == 4'hf)
    else $error("indirect bits not forced during soft reset");
endmodule

// file: tb/alu_status_flags_tb.sv
// Self-checking testbench for the ALU status and product register block.
module alu_status_flags_tb
  import alu_status_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic extResetPin = 1'b0;
  logic watchdogReset = 1'b0;
  logic [31:0] rdat;
  logic ack;
  logic [3:0] indBits;
  logic [3:0] flags;
  int nErrors = 0;
  int checked = 0;

  always #12.5 clk_sys = ~clk_sys;

  alu_status_flags u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .dat_i(wdat), .sel_i(sel), .dat_o(rdat), .ack_o(ack),
    .extResetPin(extResetPin), .watchdogReset(watchdogReset),
    .indirectModeBits(indBits), .arithFlags(flags));

  // ==========================================================================
  // Bus and checking tasks
  // ==========================================================================
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      nErrors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // The request is held until ack is sampled; the next call adds the idle cycle.
  task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (ack !== 1'b1);
    // Ack is registered, so it is seen on the second edge after the request.
    check("ack wait", 32'(n), 32'h2);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wb_write(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
    logic [31:0] r;
    wb_cycle(1'b1, a, {24'h0, d}, s, r);
  endtask

  task automatic rd_check(input string nm, input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] r;
    wb_cycle(1'b0, a, 32'h0, 4'hf, r);
    check(nm, r, {24'h0, exp});
  endtask

  task automatic exec(input aluOp_e op, input logic src, input logic dst,
    input logic [7:0] file, input logic [7:0] imm);
    logic [31:0] r;
    wb_cycle(1'b1, 8'h00, {8'h00, imm, file, 1'b0, dst, src, 5'(op)}, 4'h7, r);
  endtask

  // Loads W, runs the op with an immediate or W operand into W, checks W and status.
  task automatic arith(input aluOp_e op, input logic [7:0] w, input logic [7:0] s,
    input logic [7:0] expW, input logic [7:0] expSt);
    wb_write(8'h6c, w, 4'h1);
    exec(op, 1'b1, 1'b0, 8'h00, s);
    rd_check("result", 8'h6c, expW);
    rd_check("status", 8'h10, expSt);
  endtask

  task automatic status_op(input aluOp_e op, input logic [7:0] imm, input logic [7:0] exp);
    exec(op, 1'b0, 1'b1, 8'h04, imm);
    rd_check("status", 8'h10, exp);
  endtask

  task automatic end_test(input string nm);
    $display("test %s done, %0d compares, %0d errors", nm, checked, nErrors);
  endtask

  task automatic give_verdict();
    $display("compares %0d, mismatches %0d", checked, nErrors);
    if (nErrors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ==========================================================================
  // Tests
  // ==========================================================================
  initial
  begin
    logic [31:0] r;
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    check("indirect", {28'h0, indBits}, 32'hf);
    rd_check("status", 8'h10, 8'hf0);
    rd_check("unmapped", 8'h20, 8'h00);
    end_test("reset");
    arith(OP_ADD, 8'h7f, 8'h01, 8'h80, 8'hfa);
    arith(OP_SUB, 8'h01, 8'h00, 8'hff, 8'hf0);
    arith(OP_SUB, 8'h01, 8'h01, 8'h00, 8'hf7);
    arith(OP_SUB, 8'h01, 8'h80, 8'h7f, 8'hf9);
    arith(OP_ADD, 8'hff, 8'h01, 8'h00, 8'hf7);
    arith(OP_INC, 8'hff, 8'h00, 8'h00, 8'hf7);
    wb_write(8'h68, 8'h7f, 4'h1);
    exec(OP_INC, 1'b0, 1'b1, 8'h1a, 8'h00);
    rd_check("scratch", 8'h68, 8'h80);
    rd_check("status", 8'h10, 8'hfa);
    arith(OP_AND, 8'hf0, 8'h3c, 8'h30, 8'hfa);
    arith(OP_XOR, 8'h5a, 8'h5a, 8'h00, 8'hfe);
    arith(OP_IOR, 8'h01, 8'h80, 8'h81, 8'hfa);
    arith(OP_NEG, 8'h00, 8'h00, 8'h00, 8'hf7);
    arith(OP_ADDC, 8'h01, 8'h01, 8'h03, 8'hf0);
    arith(OP_SUBB, 8'h01, 8'h05, 8'h03, 8'hf3);
    arith(OP_RLC, 8'h81, 8'h00, 8'h03, 8'hf3);
    arith(OP_RRC, 8'h02, 8'h00, 8'h81, 8'hf2);
    arith(OP_COMP, 8'hff, 8'h00, 8'h00, 8'hf6);
    arith(OP_MOVF, 8'h80, 8'h00, 8'h80, 8'hf2);
    arith(OP_DEC, 8'h00, 8'h00, 8'hff, 8'hf0);
    arith(OP_SET, 8'h12, 8'h00, 8'hff, 8'hf0);
    end_test("arith");
    wb_write(8'h6c, 8'h12, 4'h1);
    exec(OP_MUL, 1'b1, 1'b0, 8'h00, 8'h34);
    rd_check("prodlo", 8'h60, 8'ha8);
    rd_check("prodhi", 8'h64, 8'h03);
    wb_write(8'h68, 8'h10, 4'h1);
    exec(OP_MUL, 1'b0, 1'b0, 8'h1a, 8'h00);
    rd_check("prodlo", 8'h60, 8'h20);
    rd_check("prodhi", 8'h64, 8'h01);
    end_test("multiply");
    for (int i = 0; i < 2; i++)
    begin
      wb_write(8'h10, 8'h0a, 4'h1);
      @(posedge clk_sys);
      extResetPin <= (i == 0);
      watchdogReset <= (i == 1);
      repeat (8) @(posedge clk_sys);
      extResetPin <= 1'b0;
      watchdogReset <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rd_check("prodlo", 8'h60, 8'h20);
      rd_check("prodhi", 8'h64, 8'h01);
      rd_check("status", 8'h10, 8'hfa);
    end
    end_test("soft reset");
    wb_write(8'h10, 8'h5a, 4'h1);
    status_op(OP_CLR, 8'h00, 8'h0e);
    wb_write(8'h10, 8'h35, 4'h1);
    wb_write(8'h10, 8'h00, 4'h2);
    rd_check("status", 8'h10, 8'h35);
    wb_write(8'h6c, 8'h00, 4'h1);
    status_op(OP_BSET, 8'h07, 8'hb5);
    status_op(OP_BCLR, 8'h00, 8'hb4);
    status_op(OP_SWAP, 8'h00, 8'h4b);
    status_op(OP_MOVE_W_TO_FILE_OP, 8'h00, 8'h00);
    wb_write(8'h10, 8'hf0, 4'h1);
    wb_write(8'h6c, 8'h10, 4'h1);
    status_op(OP_ADD, 8'h00, 8'h05);
    check("flags", {28'h0, flags}, 32'h5);
    wb_cycle(1'b0, 8'h00, 32'h0, 4'hf, r);
    check("command", r, 32'h00000440);
    end_test("status destination");
    give_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    nErrors++;
    give_verdict();
  end
endmodule

bind alu_status_flags alu_status_flags_assertions u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
  .dat_o(dat_o), .ack_o(ack_o), .extResetPin(extResetPin), .watchdogReset(watchdogReset),
  .indirectModeBits(indirectModeBits), .arithFlags(arithFlags));
